// >>> hdl/nvp_access_port.sv
// Processor I/O access port for the nonvolatile byte array
`timescale 1ns/1ns
`default_nettype none
module nvp_access_port (
  input  wire logic                      mclk_in,
  input  wire logic                      rst_in,
  input  wire logic [5:0]                io_addr_in,
  input  wire logic                      io_wr_in,
  input  wire logic                      io_rd_in,
  input  wire logic [7:0]                io_wdata_in,
  input  wire logic                      rc_tick_in,
  output logic [7:0]                     io_rdata_out,
  output logic                           stall_out,
  output logic                           ready_irq_out
);
  import nvp_pkg::*;
  logic [7:0] mem [SIZE_BYTES];
  logic [nvp_pkg::ADDR_W-1:0] nv_byte_address;
  logic [7:0] nv_data_byte;
  logic       read_strobe_bit;
  logic       write_strobe_bit;
  logic       write_arm_bit;
  logic       ready_irq_enable;
  logic [1:0] prog_mode;
  logic [2:0] arm_count;
  logic [2:0] stall_count;
  logic [7:0] rdata;
  logic       irq;
  logic       stall;
  nvp_state_t state;
  nvp_mode_t  op_mode;
  logic [nvp_pkg::ADDR_W-1:0] op_addr;
  logic [7:0] op_data;
  logic       timer_start;
  logic [15:0] timer_ticks;
  logic       timer_done;
  logic [nvp_pkg::ADDR_W-1:0] next_addr;
  logic [7:0] next_data;
  logic       next_read;
  logic       next_strobe;
  logic       next_arm;
  logic       next_irqen;
  logic [1:0] next_mode;
  logic [2:0] next_arm_count;
  logic [2:0] next_stall_count;
  logic [7:0] next_rdata;
  nvp_state_t next_state;
  nvp_mode_t  next_op_mode;
  logic [nvp_pkg::ADDR_W-1:0] next_op_addr;
  logic [7:0] next_op_data;
  logic       wr_ctl;
  logic       wr_hit;

  function automatic logic [7:0] ctl_image(
    input logic [1:0] mode,
    input logic       irqen,
    input logic       arm,
    input logic       strobe,
    input logic       rd
  );
    ctl_image = {2'b00, mode, irqen, arm, strobe, rd};
  endfunction

  function automatic logic [15:0] op_ticks(input nvp_mode_t m);
    op_ticks = (m == NVP_MODE_ERASE_WRITE) ? RC_TICKS_FULL : RC_TICKS_HALF;
  endfunction

  assign wr_ctl = io_wr_in && (io_addr_in == IO_CONTROL);

  nvp_rc_timer u_timer (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .start_in (timer_start),
    .tick_in  (rc_tick_in),
    .ticks_in (timer_ticks),
    .done_out (timer_done)
  );

  always_comb begin
    next_addr        = nv_byte_address;
    next_data        = nv_data_byte;
    next_read        = 1'b0;
    next_strobe      = write_strobe_bit;
    next_arm         = write_arm_bit;
    next_irqen       = ready_irq_enable;
    next_mode        = prog_mode;
    next_arm_count   = arm_count;
    next_stall_count = (stall_count != 3'h0) ? stall_count - 3'h1 : 3'h0;
    next_rdata       = 8'h00;
    next_state       = state;
    next_op_mode     = op_mode;
    next_op_addr     = op_addr;
    next_op_data     = op_data;
    timer_start      = 1'b0;
    timer_ticks      = op_ticks(op_mode);
    wr_hit           = 1'b0;
    // Arm window countdown
    if (write_arm_bit) begin
      if (arm_count == 3'h1) begin
        next_arm = 1'b0;
      end
      next_arm_count = arm_count - 3'h1;
    end
    if (io_wr_in && (state == NVP_IDLE)) begin
      if (io_addr_in == IO_ADDR_UPPER) begin
        next_addr[10:8] = io_wdata_in[2:0];
      end
      if (io_addr_in == IO_ADDR_LOWER) begin
        next_addr[7:0] = io_wdata_in;
      end
    end
    if (io_wr_in && (io_addr_in == IO_DATA)) begin
      next_data = io_wdata_in;
    end
    if (wr_ctl) begin
      next_irqen = io_wdata_in[CTL_IRQEN];
      if (state == NVP_IDLE) begin
        next_mode = io_wdata_in[CTL_MODE_HI:CTL_MODE_LO];
      end
      if (io_wdata_in[CTL_ARM] && !io_wdata_in[CTL_STROBE]) begin
        next_arm       = 1'b1;
        next_arm_count = ARM_CYCLES;
      end
      // Strobe only acts inside the armed window
      if (io_wdata_in[CTL_STROBE] && write_arm_bit &&
          (state == NVP_IDLE)) begin
        wr_hit       = 1'b1;
        next_strobe  = 1'b1;
        next_arm     = 1'b0;
        next_state   = NVP_BUSY;
        next_op_mode = nvp_mode_t'(prog_mode);
        next_op_addr = nv_byte_address;
        next_op_data = nv_data_byte;
        timer_start  = 1'b1;
        timer_ticks  = op_ticks(nvp_mode_t'(prog_mode));
        next_stall_count = WRITE_STALL;
      end else if (io_wdata_in[CTL_READ] && (state == NVP_IDLE)) begin
        next_read        = 1'b1;
        next_data        = mem[nv_byte_address];
        next_stall_count = READ_STALL;
      end
    end
    unique case (state)
      NVP_IDLE: begin
      end
      NVP_BUSY: begin
        if (timer_done) begin
          next_strobe = 1'b0;
          next_state  = NVP_IDLE;
        end
      end
    endcase
    if (io_rd_in) begin
      unique case (io_addr_in)
        IO_ADDR_UPPER: next_rdata = {5'h00, nv_byte_address[10:8]};
        IO_ADDR_LOWER: next_rdata = nv_byte_address[7:0];
        IO_DATA:       next_rdata = nv_data_byte;
        IO_CONTROL:    next_rdata = ctl_image(prog_mode, ready_irq_enable,
                                              write_arm_bit, write_strobe_bit,
                                              read_strobe_bit);
        default:       next_rdata = 8'h00;
      endcase
    end
  end

  // Array update at the end of programming
  always_ff @(posedge mclk_in) begin
    if (!rst_in && (state == NVP_BUSY) && timer_done) begin
      unique case (op_mode)
        NVP_MODE_ERASE_WRITE: mem[op_addr] <= op_data;
        NVP_MODE_ERASE_ONLY:  mem[op_addr] <= ERASED_BYTE;
        NVP_MODE_WRITE_ONLY:  mem[op_addr] <= mem[op_addr] & op_data;
        default:              mem[op_addr] <= mem[op_addr];
      endcase
    end
  end

  // Address bits keep no reset value
  always_ff @(posedge mclk_in) begin
    nv_byte_address <= next_addr;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      nv_data_byte     <= DATA_RESET;
      read_strobe_bit  <= 1'b0;
      write_strobe_bit <= 1'b0;
      write_arm_bit    <= 1'b0;
      ready_irq_enable <= 1'b0;
      prog_mode        <= 2'h0;
      arm_count        <= 3'h0;
      stall_count      <= 3'h0;
      rdata            <= 8'h00;
      irq              <= 1'b0;
      stall            <= 1'b0;
      state            <= NVP_IDLE;
      op_mode          <= NVP_MODE_ERASE_WRITE;
      op_addr          <= '0;
      op_data          <= 8'h00;
    end else begin
      nv_data_byte     <= next_data;
      read_strobe_bit  <= next_read;
      write_strobe_bit <= next_strobe;
      write_arm_bit    <= next_arm;
      ready_irq_enable <= next_irqen;
      prog_mode        <= next_mode;
      arm_count        <= next_arm_count;
      stall_count      <= next_stall_count;
      rdata            <= next_rdata;
      irq              <= next_irqen && !next_strobe;
      stall            <= next_stall_count != 3'h0;
      state            <= next_state;
      op_mode          <= next_op_mode;
      op_addr          <= next_op_addr;
      op_data          <= next_op_data;
    end
  end

  assign io_rdata_out  = rdata;
  assign stall_out     = stall;
  assign ready_irq_out = irq;
endmodule
`default_nettype wire

// >>> hdl/nvp_pkg.sv
// Constants and types for the nonvolatile byte access port
// Functional notes
// - Separate byte-wide nonvolatile space of 2048 bytes.
// - Address, data and control registers sit in the processor I/O space.
// - Writes are self-timed; the write strobe bit shows when writing may resume.
// - A triggered read stalls the processor for four clock cycles.
// - A started write stalls the processor for two clock cycles.
// - Address bits 15..11 read zero and ignore writes; bits 10..0 are read-write.
// - Bytes are addressed linearly from zero up to the array size minus one.
// - Writable address bits reset undefined; reserved address bits reset zero.
// - A write programs the data register byte at the selected address.
// - A read loads the fetched byte into the data register, which resets zero.
// - Control bits 7 and 6 are reserved and read as zero.
// - Arm bit self-clears after four cycles; strobe only acts while armed.
// - Mode field: 00 erase+write, 01 erase, 10 write, 11 reserved; locked while busy.
// - Strobe clears when programming ends; ready interrupt is high while enabled and idle.
// - Read strobe reads at once; while writing, no read and no address change.
package nvp_pkg;
  localparam int unsigned SIZE_BYTES  = 2048;
  localparam int unsigned ADDR_W      = 11;
  localparam logic [5:0] IO_ADDR_UPPER = 6'h22;
  localparam logic [5:0] IO_ADDR_LOWER = 6'h21;
  localparam logic [5:0] IO_DATA       = 6'h20;
  localparam logic [5:0] IO_CONTROL    = 6'h1F;
  localparam int unsigned CTL_READ    = 0;
  localparam int unsigned CTL_STROBE  = 1;
  localparam int unsigned CTL_ARM     = 2;
  localparam int unsigned CTL_IRQEN   = 3;
  localparam int unsigned CTL_MODE_LO = 4;
  localparam int unsigned CTL_MODE_HI = 5;
  localparam logic [7:0] DATA_RESET   = 8'h00;
  localparam logic [7:0] ERASED_BYTE  = 8'hFF;
  localparam logic [2:0] ARM_CYCLES   = 3'h4;
  localparam logic [2:0] READ_STALL   = 3'h4;
  localparam logic [2:0] WRITE_STALL  = 3'h2;
  // RC oscillator ticks per operation: full and half length
  localparam logic [15:0] RC_TICKS_FULL = 16'h6700;
  localparam logic [15:0] RC_TICKS_HALF = 16'h3800;
  typedef enum logic [1:0] {
    NVP_MODE_ERASE_WRITE = 2'h0,
    NVP_MODE_ERASE_ONLY  = 2'h1,
    NVP_MODE_WRITE_ONLY  = 2'h2,
    NVP_MODE_RESERVED    = 2'h3
  } nvp_mode_t;
  typedef enum logic [1:0] {
    NVP_IDLE = 2'b01,
    NVP_BUSY = 2'b10
  } nvp_state_t;
endpackage

// >>> hdl/nvp_rc_timer.sv
// Programming time counter on the RC tick enable
`timescale 1ns/1ns
`default_nettype none
module nvp_rc_timer (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        start_in,
  input  wire logic        tick_in,
  input  wire logic [15:0] ticks_in,
  output logic             done_out
);
  import nvp_pkg::*;
  logic        tick_q1;
  logic        tick_q2;
  logic        tick_q3;
  logic [15:0] count;
  logic        running;
  logic        done;
  logic [15:0] next_count;
  logic        next_running;
  logic        next_done;
  always_comb begin
    next_count   = count;
    next_running = running;
    next_done    = 1'b0;
    if (start_in) begin
      next_count   = ticks_in;
      next_running = 1'b1;
    end else if (running && tick_q2 && !tick_q3) begin
      if (count == 16'h0001) begin
        next_running = 1'b0;
        next_done    = 1'b1;
      end
      next_count = count - 16'h0001;
    end
  end
  always_ff @(posedge mclk_in) begin
    tick_q1 <= tick_in;
    tick_q2 <= tick_q1;
    tick_q3 <= tick_q2;
    if (rst_in) begin
      count   <= 16'h0000;
      running <= 1'b0;
      done    <= 1'b0;
    end else begin
      count   <= next_count;
      running <= next_running;
      done    <= next_done;
    end
  end
  assign done_out = done;
endmodule
`default_nettype wire

// >>> sim/nvp_access_port_assertions.sv
// Port-level checks for the nonvolatile access port
`timescale 1ns/1ns
`default_nettype none
module nvp_assertions
  import nvp_pkg::*;
(
  input wire logic       mclk_in,
  input wire logic       rst_in,
  input wire logic [5:0] io_addr_in,
  input wire logic       io_wr_in,
  input wire logic       io_rd_in,
  input wire logic [7:0] io_wdata_in,
  input wire logic       rc_tick_in,
  input wire logic [7:0] io_rdata_out,
  input wire logic       stall_out,
  input wire logic       ready_irq_out
);
  logic [2:0] run;
  wire        ctl_wr = io_wr_in && io_addr_in == IO_CONTROL;
  wire        strobe_wr = ctl_wr && io_wdata_in[CTL_STROBE];
  // Length of the current stall, saturating
  always_ff @(posedge mclk_in)
    run <= (rst_in || !stall_out) ? 3'h0 : (run == 3'h7 ? run : run + 3'h1);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  sequence s_read_hold;
    stall_out [*4] ##1 !stall_out;
  endsequence
  sequence s_write_hold;
    stall_out ##1 !stall_out;
  endsequence
  a_rdata_idle_zero: assert property (
    !io_rd_in |=> io_rdata_out == 8'h00) else $error("stray read data");
  a_read_stall_four: assert property (
    ctl_wr && io_wdata_in[1:0] == 2'h1 && ready_irq_out |=> s_read_hold)
    else $error("read stall length wrong");
  a_write_stall_two: assert property (
    $fell(ready_irq_out) && stall_out && $past(strobe_wr) |=> s_write_hold)
    else $error("write stall length wrong");
  a_stall_has_cause: assert property (
    $rose(stall_out) |-> $past(ctl_wr)) else $error("stall without trigger");
  a_stall_cap: assert property (
    run <= 3'h4) else $error("stall too long");
  a_irq_off: assert property (
    ctl_wr && !io_wdata_in[3] |=> !ready_irq_out) else $error("irq not off");
  a_irq_idle_hold: assert property (
    ctl_wr && io_wdata_in[3:1] == 3'h4 && ready_irq_out |=> ready_irq_out)
    else $error("irq dropped while idle");
  a_upper_zero: assert property (
    io_rd_in && io_addr_in == IO_ADDR_UPPER |=> io_rdata_out[7:3] == 5'h00)
    else $error("upper address bits not zero");
  a_ctl_reserved: assert property (
    io_rd_in && io_addr_in == IO_CONTROL |=> io_rdata_out[7:6] == 2'h0)
    else $error("control reserved bits set");
endmodule
bind nvp_access_port nvp_assertions u_nvp_assertions (.mclk_in, .rst_in,
  .io_addr_in, .io_wr_in, .io_rd_in, .io_wdata_in, .rc_tick_in,
  .io_rdata_out, .stall_out, .ready_irq_out);
`default_nettype wire

// >>> sim/nvp_cpu_model.sv
// Processor-side model issuing I/O register cycles
`timescale 1ns/1ns
`default_nettype none
module nvp_cpu_model (
  input  wire logic       mclk_in,
  input  wire logic       stall_in,
  input  wire logic [7:0] rdata_in,
  output var logic  [5:0] addr_out,
  output var logic        wr_out,
  output var logic        rd_out,
  output var logic  [7:0] wdata_out
);
  // Set when the core stays halted longer than any legal stall
  logic hung = 1'b0;
  initial begin
    {addr_out, wr_out, rd_out, wdata_out} = '0;
  end
  task automatic cyc(input logic [5:0] a, input logic [7:0] d,
                     input logic w, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge mclk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= w;
    rd_out    <= !w;
    @(posedge mclk_in);
    wr_out    <= 1'b0;
    rd_out    <= 1'b0;
    wdata_out <= ~d;
    #1 q = rdata_in;
    // No next instruction while the core is halted
    do begin
      @(posedge mclk_in);
      #1 n++;
    end while (stall_in && n < 8);
    if (stall_in) begin
      hung = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// >>> sim/tb_nvp_access_port.sv
// Self-checking bench for the nonvolatile access port
`timescale 1ns/1ns
`default_nettype none
module tb_nvp_access_port;
  import nvp_pkg::*;
  logic       mclk_in = 1'b0;
  logic       rst_in  = 1'b1;
  logic       rc_tick = 1'b0;
  logic [5:0] addr;
  logic       wr;
  logic       rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] q;
  logic [7:0] r;
  logic [7:0] d;
  logic       stall;
  logic       irq;
  int         n_mismatch = 0;
  int         n_tests    = 0;
  always #50 mclk_in = ~mclk_in;
  always @(posedge mclk_in) rc_tick <= ~rc_tick;
  nvp_access_port u_nvp_access_port (.mclk_in, .rst_in, .io_addr_in(addr),
    .io_wr_in(wr), .io_rd_in(rd), .io_wdata_in(wdata), .rc_tick_in(rc_tick),
    .io_rdata_out(rdata), .stall_out(stall), .ready_irq_out(irq));
  nvp_cpu_model u_nvp_cpu_model (.mclk_in, .stall_in(stall), .rdata_in(rdata),
    .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata));
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  function automatic logic [7:0] ctl(input logic [1:0] m, input logic s);
    return {2'h0, m, 1'b1, 1'b0, s, 1'b0};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // A stall that never ends counts as a failure and closes the run
  task automatic hang_check;
    if (u_nvp_cpu_model.hung) begin
      n_mismatch++;
      tally_and_finish;
    end
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] v);
    u_nvp_cpu_model.cyc(a, v, 1'b1, q);
    hang_check;
  endtask
  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    u_nvp_cpu_model.cyc(a, 8'h00, 1'b0, q);
    hang_check;
    check(q, e);
  endtask
  task automatic start(input logic [1:0] m);
    wr_reg(IO_CONTROL, {2'h0, m, 4'hC});
    wr_reg(IO_CONTROL, {2'h0, m, 4'hE});
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 40000 && irq !== 1'b1; i++)
      @(posedge mclk_in);
    if (irq !== 1'b1) begin
      n_mismatch++;
      tally_and_finish;
    end
  endtask
  initial begin
    repeat (12) @(posedge mclk_in);
    rst_in <= 1'b0;
    rc(IO_DATA, DATA_RESET);
    rc(IO_CONTROL, 8'h00);
    wr_reg(IO_CONTROL, 8'h00);
    wr_reg(IO_ADDR_UPPER, 8'hFF);
    rc(IO_ADDR_UPPER, 8'h07);
    r = lfsr(8'h5B);
    d = lfsr(r);
    wr_reg(IO_ADDR_UPPER, r);
    wr_reg(IO_ADDR_LOWER, d);
    rc(IO_ADDR_LOWER, d);
    for (int m = 0; m < 3; m++) begin
      wr_reg(IO_CONTROL, ctl(m[1:0], 1'b0));
      rc(IO_CONTROL, ctl(m[1:0], 1'b0));
    end
    wr_reg(IO_CONTROL, 8'h0A);
    rc(IO_CONTROL, ctl(2'h0, 1'b0));
    wr_reg(IO_CONTROL, 8'h0C);
    repeat (5) @(posedge mclk_in);
    wr_reg(IO_CONTROL, 8'h0A);
    rc(IO_CONTROL, ctl(2'h0, 1'b0));
    start(2'h1);
    wr_reg(IO_CONTROL, 8'h3A);
    wr_reg(IO_ADDR_UPPER, ~r);
    rc(IO_CONTROL, ctl(2'h1, 1'b1));
    check({7'h00, irq}, 8'h00);
    rc(IO_ADDR_UPPER, {5'h00, r[2:0]});
    wait_idle;
    rc(IO_CONTROL, ctl(2'h1, 1'b0));
    wr_reg(IO_CONTROL, 8'h19);
    rc(IO_DATA, ERASED_BYTE);
    d = lfsr(d);
    wr_reg(IO_DATA, d);
    start(2'h2);
    wait_idle;
    wr_reg(IO_CONTROL, 8'h09);
    rc(IO_DATA, d);
    tally_and_finish;
  end
endmodule
`default_nettype wire
